// file: gpio_steer_pkg.sv
`default_nettype none
package gpio_steer_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int unsigned NPORT = 3;
  localparam int unsigned PORT_A = 0;
  localparam int unsigned PORT_B = 1;
  localparam int unsigned PORT_C = 2;

  ////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses (port base = index * stride)
  localparam logic [7:0] PORT_STRIDE = 8'h20;
  localparam logic [4:0] OFS_DIR     = 5'h00;
  localparam logic [4:0] OFS_LEVEL   = 5'h04;
  localparam logic [4:0] OFS_LATCH   = 5'h08;
  localparam logic [4:0] OFS_ANALOG  = 5'h0c;
  localparam logic [4:0] OFS_PULLUP  = 5'h10;
  localparam logic [4:0] OFS_OWNER   = 5'h14;
  localparam logic [7:0] OFS_ALT_SEL = 8'h60;

  ////////////////////////////////////////////////////////////////////////
  // Implemented pins, analog-capable pins, input-only pins; index 0 = port A
  localparam logic [NPORT-1:0][7:0] PIN_MASK   = {8'hff, 8'hf0, 8'h3f};
  localparam logic [NPORT-1:0][7:0] ANA_MASK   = {8'hcf, 8'h30, 8'h17};
  localparam logic [NPORT-1:0][7:0] INPUT_ONLY = {8'h00, 8'h00, 8'h08};

  ////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0] LATCH_RST   = 8'h00;
  localparam logic [7:0] PULLUP_RST  = 8'h00;
  localparam logic [7:0] ALT_SEL_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Alternate pin select fields
  localparam logic [7:0] ALT_SEL_MASK        = 8'h1b;
  localparam int unsigned SLAVE_SELECT_PIN_SEL = 4;
  localparam int unsigned TIMER_GATE_PIN_SEL   = 3;
  localparam int unsigned LOGIC_CELL_PIN_SEL   = 1;
  localparam int unsigned OSC_OUTPUT_PIN_SEL   = 0;

  // Pin positions inside their port
  localparam int unsigned RA2 = 2;
  localparam int unsigned RA3 = 3;
  localparam int unsigned RA4 = 4;
  localparam int unsigned RC1 = 1;
  localparam int unsigned RC5 = 5;
  localparam int unsigned RC6 = 6;

endpackage : gpio_steer_pkg
`default_nettype wire

// file: alt_pin_router.sv
`timescale 1ns/10ps
`default_nettype none
module alt_pin_router
  import gpio_steer_pkg::*;
(
  input  wire logic [7:0] alt_sel,
  input  wire logic [7:0] dig_a,
  input  wire logic [7:0] dig_c,
  input  wire logic       lc_val,
  input  wire logic       lc_en,
  input  wire logic       osc_val,
  input  wire logic       osc_en,
  output logic            slave_sel_in,
  output logic            timer_gate_in,
  output logic [7:0]      ovr_en_a,
  output logic [7:0]      ovr_val_a,
  output logic [7:0]      ovr_en_c,
  output logic [7:0]      ovr_val_c
);

  // Pure decode of the live select value; no state here
  always_comb
  begin
    ovr_en_a  = 8'h00;
    ovr_val_a = 8'h00;
    ovr_en_c  = 8'h00;
    ovr_val_c = 8'h00;
    slave_sel_in  = alt_sel[SLAVE_SELECT_PIN_SEL] ? dig_a[RA3] : dig_c[RC6];
    timer_gate_in = alt_sel[TIMER_GATE_PIN_SEL] ? dig_a[RA3] : dig_a[RA4];
    if (alt_sel[LOGIC_CELL_PIN_SEL])
    begin
      ovr_en_c[RC5]  = lc_en;
      ovr_val_c[RC5] = lc_val;
    end
    else
    begin
      ovr_en_a[RA2]  = lc_en;
      ovr_val_a[RA2] = lc_val;
    end
    if (alt_sel[OSC_OUTPUT_PIN_SEL])
    begin
      ovr_en_c[RC6]  = osc_en;
      ovr_val_c[RC6] = osc_val;
    end
    else
    begin
      ovr_en_c[RC1]  = osc_en;
      ovr_val_c[RC1] = osc_val;
    end
  end

endmodule : alt_pin_router
`default_nettype wire

// file: pin_out_resolve.sv
`timescale 1ns/10ps
`default_nettype none
module pin_out_resolve
(
  input  wire logic [7:0] drive_ok,
  input  wire logic [7:0] dir,
  input  wire logic [7:0] latch,
  input  wire logic [7:0] fn_en,
  input  wire logic [7:0] fn_val,
  input  wire logic [7:0] ovr_en,
  input  wire logic [7:0] ovr_val,
  output logic [7:0]      pin_out,
  output logic [7:0]      pin_oe_n,
  output logic [7:0]      owned
);

  // Fixed order per pin: steered function, other peripheral, then latch
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      owned[i] = drive_ok[i] & (ovr_en[i] | fn_en[i]);
      if (!drive_ok[i])
      begin
        pin_out[i]  = 1'b0;
        pin_oe_n[i] = 1'b1;
      end
      else if (ovr_en[i])
      begin
        pin_out[i]  = ovr_val[i];
        pin_oe_n[i] = 1'b0;
      end
      else if (fn_en[i])
      begin
        pin_out[i]  = fn_val[i];
        pin_oe_n[i] = 1'b0;
      end
      else
      begin
        pin_out[i]  = latch[i];
        pin_oe_n[i] = dir[i];
      end
    end
  end

endmodule : pin_out_resolve
`default_nettype wire

// file: io_port_steer.sv
`timescale 1ns/10ps
`default_nettype none
module io_port_steer
  import gpio_steer_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  PA_IN,
  output logic [7:0]       PA_OUT,
  output logic [7:0]       PA_OE_N,
  output logic [7:0]       PA_ANALOG,
  output logic [7:0]       PA_PULLUP,
  input  wire logic [7:0]  PA_FN_EN,
  input  wire logic [7:0]  PA_FN_VAL,
  output logic [7:0]       PA_DIG,
  input  wire logic [7:0]  PB_IN,
  output logic [7:0]       PB_OUT,
  output logic [7:0]       PB_OE_N,
  output logic [7:0]       PB_ANALOG,
  output logic [7:0]       PB_PULLUP,
  input  wire logic [7:0]  PB_FN_EN,
  input  wire logic [7:0]  PB_FN_VAL,
  output logic [7:0]       PB_DIG,
  input  wire logic [7:0]  PC_IN,
  output logic [7:0]       PC_OUT,
  output logic [7:0]       PC_OE_N,
  output logic [7:0]       PC_ANALOG,
  output logic [7:0]       PC_PULLUP,
  input  wire logic [7:0]  PC_FN_EN,
  input  wire logic [7:0]  PC_FN_VAL,
  output logic [7:0]       PC_DIG,
  input  wire logic        LOGIC_CELL_ONE_OUTPUT,
  input  wire logic        LOGIC_CELL_ONE_EN,
  input  wire logic        NUMERIC_OSC_OUTPUT,
  input  wire logic        NUMERIC_OSC_EN,
  output logic             SLAVE_SELECT_INPUT,
  output logic             TIMER_GATE_INPUT
);

  //////////////////////////////////////////////////////////////////////////
  // State

  typedef logic [NPORT-1:0][7:0] port_vec_t;

  typedef struct packed {
    port_vec_t   pin_direction_reg;
    port_vec_t   output_latch_reg;
    port_vec_t   analog_select_reg;
    port_vec_t   weak_pullup_reg;
    logic [7:0]  alt_pin_select_reg;
    port_vec_t   pin_out;
    port_vec_t   pin_oe_n;
    port_vec_t   pin_dig;
    logic [31:0] rdata;
    logic        slave_sel;
    logic        timer_gate;
  } state_t;

  localparam state_t STATE_RST = '{
    pin_direction_reg:  PIN_MASK,
    output_latch_reg:   {NPORT{LATCH_RST}},
    analog_select_reg:  ANA_MASK,
    weak_pullup_reg:    {NPORT{PULLUP_RST}},
    alt_pin_select_reg: ALT_SEL_RST,
    pin_out:            '0,
    pin_oe_n:           '1,
    pin_dig:            '0,
    rdata:              32'h0000_0000,
    slave_sel:          1'b0,
    timer_gate:         1'b0
  };

  state_t s_r;
  state_t s_nxt;

  logic [1:0] rst_sync_r;
  logic       rst_n;

  port_vec_t  pin_in;
  port_vec_t  fn_en;
  port_vec_t  fn_val;
  port_vec_t  dig;
  port_vec_t  ovr_en;
  port_vec_t  ovr_val;
  logic [7:0] ovr_en_a;
  logic [7:0] ovr_val_a;
  logic [7:0] ovr_en_c;
  logic [7:0] ovr_val_c;
  port_vec_t  res_out;
  port_vec_t  res_oe_n;
  port_vec_t  owned;
  logic       slave_sel_in;
  logic       timer_gate_in;
  logic       setup_ph;
  logic       access_ph;
  logic       addr_hit;

  //////////////////////////////////////////////////////////////////////////
  // Reset release

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_sync_r <= 2'b00;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  //////////////////////////////////////////////////////////////////////////
  // Address decode helpers, shared by the read and write paths

  function automatic logic [1:0] port_of(input logic [7:0] a);
    port_of = a[6:5];
  endfunction : port_of

  function automatic logic is_alt(input logic [7:0] a);
    is_alt = (a == OFS_ALT_SEL);
  endfunction : is_alt

  function automatic logic [4:0] reg_of(input logic [7:0] a);
    reg_of = a[4:0];
  endfunction : reg_of

  function automatic logic is_port_reg(input logic [7:0] a);
    logic [4:0] f;
    f = reg_of(a);
    is_port_reg = !a[7] && (a[6:5] < 2'(NPORT)) &&
                  (f == OFS_DIR || f == OFS_LEVEL || f == OFS_LATCH ||
                   f == OFS_ANALOG || f == OFS_PULLUP || f == OFS_OWNER);
  endfunction : is_port_reg

  //////////////////////////////////////////////////////////////////////////
  // Pin side

  assign pin_in = {PC_IN, PB_IN, PA_IN};
  assign fn_en  = {PC_FN_EN, PB_FN_EN, PA_FN_EN};
  assign fn_val = {PC_FN_VAL, PB_FN_VAL, PA_FN_VAL};

  // Analog pins have their input buffer off, so every digital consumer sees 0
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      dig[p] = pin_in[p] & ~s_r.analog_select_reg[p] & PIN_MASK[p];
    end
  end

  alt_pin_router u_router (
    .alt_sel       (s_r.alt_pin_select_reg),
    .dig_a         (dig[PORT_A]),
    .dig_c         (dig[PORT_C]),
    .lc_val        (LOGIC_CELL_ONE_OUTPUT),
    .lc_en         (LOGIC_CELL_ONE_EN),
    .osc_val       (NUMERIC_OSC_OUTPUT),
    .osc_en        (NUMERIC_OSC_EN),
    .slave_sel_in  (slave_sel_in),
    .timer_gate_in (timer_gate_in),
    .ovr_en_a      (ovr_en_a),
    .ovr_val_a     (ovr_val_a),
    .ovr_en_c      (ovr_en_c),
    .ovr_val_c     (ovr_val_c)
  );

  // No steered function lands on port B; one process owns each override vector
  always_comb
  begin
    ovr_en          = '0;
    ovr_val         = '0;
    ovr_en[PORT_A]  = ovr_en_a;
    ovr_val[PORT_A] = ovr_val_a;
    ovr_en[PORT_C]  = ovr_en_c;
    ovr_val[PORT_C] = ovr_val_c;
  end

  for (genvar g = 0; g < NPORT; g++)
  begin : g_port
    pin_out_resolve u_resolve (
      .drive_ok (PIN_MASK[g] & ~INPUT_ONLY[g]),
      .dir      (s_r.pin_direction_reg[g]),
      .latch    (s_r.output_latch_reg[g]),
      .fn_en    (fn_en[g]),
      .fn_val   (fn_val[g]),
      .ovr_en   (ovr_en[g]),
      .ovr_val  (ovr_val[g]),
      .pin_out  (res_out[g]),
      .pin_oe_n (res_oe_n[g]),
      .owned    (owned[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus side: zero wait states, read data captured in the setup cycle

  assign setup_ph  = PSEL & ~PENABLE;
  assign access_ph = PSEL & PENABLE;
  assign addr_hit  = is_port_reg(PADDR) | is_alt(PADDR);
  assign PREADY    = 1'b1;
  assign PSLVERR   = access_ph & ~addr_hit;

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [1:0]  p;
    logic [7:0]  wd;
    logic [7:0]  rd;
    s_nxt = s_r;
    p     = port_of(PADDR);
    wd    = PWDATA[7:0];
    rd    = 8'h00;

    // Pads follow the resolved drive one cycle later
    s_nxt.pin_out    = res_out;
    s_nxt.pin_oe_n   = res_oe_n;
    s_nxt.pin_dig    = dig;
    s_nxt.slave_sel  = slave_sel_in;
    s_nxt.timer_gate = timer_gate_in;

    // Only the completing access edge changes a register
    if (access_ph && PWRITE)
    begin
      if (is_alt(PADDR))
      begin
        // Direction is left as it stands; the override still drives the steered pin whatever its direction bit
        s_nxt.alt_pin_select_reg = wd & ALT_SEL_MASK;
      end
      else if (is_port_reg(PADDR))
      begin
        case (reg_of(PADDR))
          OFS_DIR:
          begin
            s_nxt.pin_direction_reg[p] = (wd | INPUT_ONLY[p]) & PIN_MASK[p];
          end
          OFS_LEVEL, OFS_LATCH:
          begin
            s_nxt.output_latch_reg[p] = wd & PIN_MASK[p];
          end
          OFS_ANALOG:
          begin
            s_nxt.analog_select_reg[p] = wd & ANA_MASK[p];
          end
          OFS_PULLUP:
          begin
            s_nxt.weak_pullup_reg[p] = wd & PIN_MASK[p];
          end
          default:
          begin
            s_nxt.rdata = s_r.rdata;
          end
        endcase
      end
    end

    if (setup_ph && !PWRITE)
    begin
      if (is_alt(PADDR))
      begin
        rd = s_r.alt_pin_select_reg;
      end
      else if (is_port_reg(PADDR))
      begin
        case (reg_of(PADDR))
          OFS_DIR:    rd = s_r.pin_direction_reg[p];
          OFS_LEVEL:  rd = dig[p];
          OFS_LATCH:  rd = s_r.output_latch_reg[p];
          OFS_ANALOG: rd = s_r.analog_select_reg[p];
          OFS_PULLUP: rd = s_r.weak_pullup_reg[p];
          OFS_OWNER:  rd = owned[p];
          default:    rd = 8'h00;
        endcase
      end
      s_nxt.rdata = {24'h00_0000, rd};
    end
    else if (setup_ph)
    begin
      s_nxt.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= STATE_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign PRDATA             = s_r.rdata;
  assign PA_OUT             = s_r.pin_out[PORT_A];
  assign PB_OUT             = s_r.pin_out[PORT_B];
  assign PC_OUT             = s_r.pin_out[PORT_C];
  assign PA_OE_N            = s_r.pin_oe_n[PORT_A];
  assign PB_OE_N            = s_r.pin_oe_n[PORT_B];
  assign PC_OE_N            = s_r.pin_oe_n[PORT_C];
  assign PA_ANALOG          = s_r.analog_select_reg[PORT_A];
  assign PB_ANALOG          = s_r.analog_select_reg[PORT_B];
  assign PC_ANALOG          = s_r.analog_select_reg[PORT_C];
  assign PA_PULLUP          = s_r.weak_pullup_reg[PORT_A];
  assign PB_PULLUP          = s_r.weak_pullup_reg[PORT_B];
  assign PC_PULLUP          = s_r.weak_pullup_reg[PORT_C];
  assign PA_DIG             = s_r.pin_dig[PORT_A];
  assign PB_DIG             = s_r.pin_dig[PORT_B];
  assign PC_DIG             = s_r.pin_dig[PORT_C];
  assign SLAVE_SELECT_INPUT = s_r.slave_sel;
  assign TIMER_GATE_INPUT   = s_r.timer_gate;

endmodule : io_port_steer
`default_nettype wire

// file: io_port_steer_chk.sv
`timescale 1ns/10ps
`default_nettype none
module io_port_steer_chk
  import gpio_steer_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        NRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [7:0]  PA_IN,
  input wire logic [7:0]  PA_OUT,
  input wire logic [7:0]  PA_OE_N,
  input wire logic [7:0]  PA_ANALOG,
  input wire logic [7:0]  PA_DIG,
  input wire logic [7:0]  PB_OUT,
  input wire logic [7:0]  PB_OE_N,
  input wire logic [7:0]  PB_FN_EN,
  input wire logic [7:0]  PB_FN_VAL,
  input wire logic [7:0]  PC_IN,
  input wire logic [7:0]  PC_OUT,
  input wire logic [7:0]  PC_OE_N,
  input wire logic [7:0]  PC_ANALOG,
  input wire logic        LOGIC_CELL_ONE_OUTPUT,
  input wire logic        LOGIC_CELL_ONE_EN,
  input wire logic        NUMERIC_OSC_OUTPUT,
  input wire logic        NUMERIC_OSC_EN,
  input wire logic        SLAVE_SELECT_INPUT,
  input wire logic        TIMER_GATE_INPUT
);
  logic [2:0] up_r;
  logic [7:0] alt_r;
  logic       live;

  // Shadow of the select register; checks wait out the two-flop reset release
  always_ff @(posedge CLK_SYS or negedge NRST)
    if (!NRST)
      {up_r, alt_r} <= '0;
    else
    begin
      up_r <= up_r + 3'(up_r != 3'h5);
      if (PSEL && PENABLE && PWRITE && PADDR == OFS_ALT_SEL)
        alt_r <= PWDATA[7:0] & ALT_SEL_MASK;
    end
  assign live = (up_r == 3'h5);

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  sequence s_lc(sel);
    live && LOGIC_CELL_ONE_EN && alt_r[1] == sel;
  endsequence
  sequence s_osc(sel);
    live && NUMERIC_OSC_EN && alt_r[0] == sel;
  endsequence

  a_lc_ra2: assert property (s_lc(0) |=> !PA_OE_N[RA2] && PA_OUT[RA2] == $past(LOGIC_CELL_ONE_OUTPUT))
    else $error("logic cell not on RA2");
  a_lc_rc5: assert property (s_lc(1) |=> !PC_OE_N[RC5] && PC_OUT[RC5] == $past(LOGIC_CELL_ONE_OUTPUT))
    else $error("logic cell not on RC5");
  a_osc_rc1: assert property (s_osc(0) |=> !PC_OE_N[RC1] && PC_OUT[RC1] == $past(NUMERIC_OSC_OUTPUT))
    else $error("oscillator not on RC1");
  a_osc_rc6: assert property (s_osc(1) |=> !PC_OE_N[RC6] && PC_OUT[RC6] == $past(NUMERIC_OSC_OUTPUT))
    else $error("oscillator not on RC6");
  a_gate_pin: assert property (live && !PA_ANALOG[RA4] ##1 !PA_ANALOG[RA4] |->
    TIMER_GATE_INPUT == $past(alt_r[3] ? PA_IN[RA3] : PA_IN[RA4])) else $error("timer gate from wrong pin");
  a_ss_pin: assert property (live && !PC_ANALOG[RC6] ##1 !PC_ANALOG[RC6] |->
    SLAVE_SELECT_INPUT == $past(alt_r[4] ? PA_IN[RA3] : PC_IN[RC6])) else $error("slave select from wrong pin");
  a_dig_masked: assert property (live ##1 $stable(PA_ANALOG) |->
    PA_DIG == ($past(PA_IN) & ~PA_ANALOG & PIN_MASK[PORT_A])) else $error("digital input not masked");
  a_ra3_input: assert property (live |-> PA_OE_N[RA3])
    else $error("input-only pin driven");
  a_fn_owns: assert property (live |=>
    ((PB_OE_N | (PB_OUT ^ $past(PB_FN_VAL))) & $past(PB_FN_EN) & PIN_MASK[PORT_B]) == 8'h00)
    else $error("peripheral lost its pin");
endmodule : io_port_steer_chk

bind io_port_steer io_port_steer_chk i_chk
(
  .CLK_SYS, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PA_IN, .PA_OUT, .PA_OE_N, .PA_ANALOG, .PA_DIG,
  .PB_OUT, .PB_OE_N, .PB_FN_EN, .PB_FN_VAL, .PC_IN, .PC_OUT, .PC_OE_N, .PC_ANALOG, .LOGIC_CELL_ONE_OUTPUT,
  .LOGIC_CELL_ONE_EN, .NUMERIC_OSC_OUTPUT, .NUMERIC_OSC_EN, .SLAVE_SELECT_INPUT, .TIMER_GATE_INPUT
);
`default_nettype wire

// file: pin_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module pin_far_side
(
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] ext,
  output logic [7:0]      pin_in
);
  // The board always drives released pins, so a tri-stated pin shows the board level
  assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule : pin_far_side
`default_nettype wire

// file: io_port_steer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module io_port_steer_tb
  import gpio_steer_pkg::*;
();
  logic             clk, nrst, psel, penable, pwrite, perr, lc_v, lc_en, osc_v, osc_en;
  logic [7:0]       paddr, alt;
  logic [31:0]      pwdata, lfsr;
  logic [7:0]       ext [3], fn_en [3], fn_val [3], dir [3], lat [3], ana [3], pu [3];
  wire logic        pready, pslverr, ss_in, gate_in;
  wire logic [31:0] prdata;
  wire logic [7:0]  p_in [3], p_out [3], p_oe_n [3], p_ana [3], p_pu [3], p_dig [3];
  int               err_total, checks_done;

  io_port_steer i_dut
  (
    .CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PA_IN(p_in[0]), .PA_OUT(p_out[0]), .PA_OE_N(p_oe_n[0]), .PA_FN_EN(fn_en[0]), .PA_FN_VAL(fn_val[0]),
    .PB_IN(p_in[1]), .PB_OUT(p_out[1]), .PB_OE_N(p_oe_n[1]), .PB_FN_EN(fn_en[1]), .PB_FN_VAL(fn_val[1]),
    .PC_IN(p_in[2]), .PC_OUT(p_out[2]), .PC_OE_N(p_oe_n[2]), .PC_FN_EN(fn_en[2]), .PC_FN_VAL(fn_val[2]),
    .PA_ANALOG(p_ana[0]), .PA_PULLUP(p_pu[0]), .PA_DIG(p_dig[0]), .PB_ANALOG(p_ana[1]), .PB_PULLUP(p_pu[1]),
    .PB_DIG(p_dig[1]), .PC_ANALOG(p_ana[2]), .PC_PULLUP(p_pu[2]), .PC_DIG(p_dig[2]),
    .LOGIC_CELL_ONE_OUTPUT(lc_v), .LOGIC_CELL_ONE_EN(lc_en), .NUMERIC_OSC_OUTPUT(osc_v),
    .NUMERIC_OSC_EN(osc_en), .SLAVE_SELECT_INPUT(ss_in), .TIMER_GATE_INPUT(gate_in)
  );

  for (genvar g = 0; g < 3; g++)
  begin : g_pins
    pin_far_side i_pins (.pin_out(p_out[g]), .pin_oe_n(p_oe_n[g]), .ext(ext[g]), .pin_in(p_in[g]));
  end

  initial
  begin
    clk = 1'b0;
    forever
      #2.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic roll;
    lfsr = lfsr_next(lfsr);
  endtask : roll

  // Request held until pready is seen high; one idle edge keeps drivers from double assignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, {lfsr[31:8], d}, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, lfsr, q);
    chk(q, e);
  endtask : rd

  function automatic logic [7:0] base(input int p);
    return 8'(p) * PORT_STRIDE;
  endfunction : base

  // Pins the port drives: a peripheral claim beats the direction bit
  function automatic logic [7:0] drv(input int p);
    return (fn_en[p] | ~dir[p]) & PIN_MASK[p] & ~INPUT_ONLY[p];
  endfunction : drv

  task automatic check_regs;
    logic [7:0] d, o, l;
    for (int p = 0; p < 3; p++)
    begin
      d = drv(p);
      o = (fn_en[p] & fn_val[p]) | (~fn_en[p] & lat[p]);
      l = ((d & o) | (~d & ext[p])) & ~ana[p] & PIN_MASK[p];
      chk(p_oe_n[p], 8'(~d));
      chk(p_out[p] & d, o & d);
      chk(p_ana[p], ana[p]);
      chk(p_pu[p], pu[p]);
      chk(p_dig[p], l);
      rd(base(p) + OFS_DIR, dir[p]);
      rd(base(p) + OFS_LATCH, lat[p]);
      rd(base(p) + OFS_ANALOG, ana[p]);
      rd(base(p) + OFS_PULLUP, pu[p]);
      rd(base(p) + OFS_LEVEL, l);
      rd(base(p) + OFS_OWNER, fn_en[p] & PIN_MASK[p] & ~INPUT_ONLY[p]);
    end
    rd(OFS_ALT_SEL, alt);
  endtask : check_regs

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, lc_v, lc_en, osc_v, osc_en} = '0;
    ext = '{default: 8'h00};
    fn_en = '{default: 8'h00};
    fn_val = '{default: 8'h00};
    lfsr = 32'hc29d9a03;
    alt = ALT_SEL_RST;
    for (int p = 0; p < 3; p++)
    begin
      dir[p] = PIN_MASK[p];
      lat[p] = LATCH_RST;
      ana[p] = ANA_MASK[p];
      pu[p] = PULLUP_RST;
    end
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    check_regs();
    rd(8'h64, 32'h0);
    chk(perr, 1'b1);
    $display("test reset values done");
    for (int r = 0; r < 6; r++)
    begin
      for (int p = 0; p < 3; p++)
      begin
        roll();
        wr(base(p) + OFS_DIR, lfsr[7:0]);
        dir[p] = (lfsr[7:0] & PIN_MASK[p] & ~INPUT_ONLY[p]) | INPUT_ONLY[p];
        roll();
        wr(base(p) + (r[0] ? OFS_LEVEL : OFS_LATCH), lfsr[7:0]);
        lat[p] = lfsr[7:0] & PIN_MASK[p];
        roll();
        wr(base(p) + OFS_ANALOG, lfsr[7:0]);
        ana[p] = lfsr[7:0] & ANA_MASK[p];
        roll();
        wr(base(p) + OFS_PULLUP, lfsr[7:0]);
        pu[p] = lfsr[7:0] & PIN_MASK[p];
        roll();
        ext[p] <= lfsr[7:0];
        fn_en[p] <= (r > 2) ? lfsr[15:8] : 8'h00;
        fn_val[p] <= lfsr[23:16];
      end
      roll();
      wr(OFS_ALT_SEL, lfsr[7:0]);
      alt = lfsr[7:0] & ALT_SEL_MASK;
      repeat (4) @(posedge clk);
      check_regs();
    end
    $display("test random registers done");
    for (int p = 0; p < 3; p++)
    begin
      wr(base(p) + OFS_DIR, 8'hff);
      wr(base(p) + OFS_ANALOG, 8'h00);
      dir[p] = PIN_MASK[p];
      fn_en[p] <= 8'h00;
    end
    lc_en <= 1'b1;
    osc_en <= 1'b1;
    for (int s = 0; s < 16; s++)
    begin
      roll();
      lc_v <= lfsr[0];
      osc_v <= lfsr[1];
      ext <= '{lfsr[15:8], lfsr[23:16], lfsr[31:24]};
      wr(OFS_ALT_SEL, {3'h0, s[3:2], 1'b0, s[1:0]});
      repeat (3) @(posedge clk);
      chk(p_oe_n[0], 8'(~(s[1] ? 8'h00 : 8'h04)));
      chk(p_oe_n[1], 8'hff);
      chk(p_oe_n[2], 8'(~{1'b0, s[0], s[1], 3'h0, ~s[0], 1'b0}));
      chk(s[1] ? p_out[2][RC5] : p_out[0][RA2], lc_v);
      chk(s[0] ? p_out[2][RC6] : p_out[2][RC1], osc_v);
      chk(gate_in, s[2] ? ext[0][RA3] : ext[0][RA4]);
      chk(ss_in, s[3] ? ext[0][RA3] : (s[0] ? osc_v : ext[2][RC6]));
      rd(base(s % 3) + OFS_DIR, dir[s % 3]);
    end
    $display("test steering done");
    give_verdict();
  end
endmodule : io_port_steer_tb
`default_nettype wire
